// ---- core/ddc_pkg.sv ----
// Constants, types and helpers for the dual converter two-wire control block
package ddc_pkg;

    // ========================================
    // Bus address and framing
    localparam logic [5:0] ADDR_HI_BASE = 6'h06;
    localparam logic [5:0] ADDR_HI_ALT = 6'h11;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ========================================
    // Shift word layout
    localparam int PD_HI = 15;
    localparam int PD_LO = 14;
    localparam int CLR_BIT = 13;
    localparam int LOAD_OUTPUTS_N_BIT = 12;
    localparam int CODE_MSB = 11;
    localparam int RESOLUTION = 12;
    // Full 12-bit resolution keeps every code bit
    localparam logic [15:0] DATA_MASK = 16'hffff;
    localparam logic [15:0] READBACK_DEFAULT = 16'h2000;

    // ========================================
    // Pointer byte
    localparam int SEL_A = 0;
    localparam int SEL_B = 1;
    localparam logic [1:0] PTR_ONLY_A = 2'h1;
    localparam logic [1:0] PTR_ONLY_B = 2'h2;

    // ========================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGN
    } ddc_state_e;

    typedef struct packed {
        logic [1:0] power_mode;
        logic [11:0] code;
    } ddc_chan_s;

    typedef struct packed {
        ddc_state_e st;
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic strap_m;
        logic strap_s;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] hold;
        logic rw;
        logic [1:0] bcnt;
        logic [1:0] ptr;
        logic tx_lo;
        logic nack;
        logic sda_oe;
        logic sda_o;
        logic [1:0] wr;
        logic [1:0][15:0] inp;
        ddc_chan_s [1:0] ch;
    } ddc_regs_s;

    // ========================================
    // Readback word for the current pointer
    function automatic logic [15:0] rb_word(input logic [1:0] ptr,
                                            input logic [1:0][15:0] inp);
        logic [15:0] w;
        w = READBACK_DEFAULT;
        if (ptr == PTR_ONLY_A)
            w = inp[SEL_A];
        else if (ptr == PTR_ONLY_B)
            w = inp[SEL_B];
        return w;
    endfunction : rb_word

endpackage : ddc_pkg

// ---- core/ddc_top.sv ----
// Two-wire slave and double-buffered register control for a dual converter
`timescale 1ns/1ps
`default_nettype none

module ddc_top #(
    parameter bit ALT_BUILD = 1'b0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_strap_pin,
    output ddc_pkg::ddc_chan_s chan_a,
    output ddc_pkg::ddc_chan_s chan_b
);

    // ========================================
    // State
    ddc_pkg::ddc_regs_s q;
    ddc_pkg::ddc_regs_s next_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic commit;
    logic [15:0] cw;
    logic [6:0] own_addr;
    logic [15:0] rb;

    // ========================================
    // Next state
    always_comb
    begin
        next_q = q;
        commit = 1'b0;
        cw = {q.hold, q.shift};
        rb = ddc_pkg::rb_word(q.ptr, q.inp);
        own_addr = {(ALT_BUILD ? ddc_pkg::ADDR_HI_ALT : ddc_pkg::ADDR_HI_BASE),
                    q.strap_s};
        // Pins sampled twice; edges compare the second stage with a third delayed stage
        next_q.scl_m = scl;
        next_q.scl_s = q.scl_m;
        next_q.scl_d = q.scl_s;
        next_q.sda_m = sda_in;
        next_q.sda_s = q.sda_m;
        next_q.sda_d = q.sda_s;
        next_q.strap_m = address_strap_pin;
        next_q.strap_s = q.strap_m;
        rise = q.scl_s & ~q.scl_d;
        fall = ~q.scl_s & q.scl_d;
        start = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
        stop = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;
        if (start)
        begin
            next_q.st = ddc_pkg::ST_ADDR;
            next_q.cnt = '0;
            next_q.sda_oe = 1'b0;
        end
        else if (stop)
        begin
            // A stop mid-word drops the partial word
            next_q.st = ddc_pkg::ST_IDLE;
            next_q.sda_oe = 1'b0;
        end
        else
        begin
            unique case (q.st)
                ddc_pkg::ST_IDLE, ddc_pkg::ST_IGN:
                begin
                    next_q.sda_oe = 1'b0;
                end
                ddc_pkg::ST_ADDR, ddc_pkg::ST_RX:
                begin
                    if (rise)
                    begin
                        next_q.shift = {q.shift[6:0], q.sda_s};
                        next_q.cnt = q.cnt + 4'h1;
                    end
                    if (fall && q.cnt == ddc_pkg::BYTE_BITS)
                    begin
                        next_q.cnt = '0;
                        next_q.st = ddc_pkg::ST_ACK;
                        next_q.sda_oe = 1'b1;
                        if (q.st == ddc_pkg::ST_ADDR)
                        begin
                            next_q.rw = q.shift[0];
                            next_q.bcnt = 2'h0;
                            if (q.shift[7:1] != own_addr)
                            begin
                                next_q.st = ddc_pkg::ST_IGN;
                                next_q.sda_oe = 1'b0;
                            end
                        end
                        else
                        begin
                            unique case (q.bcnt)
                                2'h0:
                                begin
                                    next_q.ptr = q.shift[1:0];
                                    next_q.bcnt = 2'h1;
                                end
                                2'h1:
                                begin
                                    next_q.hold = q.shift;
                                    next_q.bcnt = 2'h2;
                                end
                                default:
                                begin
                                    commit = 1'b1;
                                    next_q.bcnt = 2'h1;
                                end
                            endcase
                        end
                    end
                end
                ddc_pkg::ST_ACK:
                begin
                    if (fall)
                    begin
                        next_q.sda_oe = 1'b0;
                        next_q.st = ddc_pkg::ST_RX;
                        if (q.rw)
                        begin
                            // Held pointer chooses the word
                            next_q.st = ddc_pkg::ST_TX;
                            next_q.tx = rb[15:8];
                            next_q.sda_oe = ~rb[15];
                            next_q.tx_lo = 1'b1;
                        end
                    end
                end
                ddc_pkg::ST_TX:
                begin
                    if (rise)
                        next_q.cnt = q.cnt + 4'h1;
                    if (fall)
                    begin
                        if (q.cnt == ddc_pkg::BYTE_BITS)
                        begin
                            next_q.st = ddc_pkg::ST_MACK;
                            next_q.sda_oe = 1'b0;
                            next_q.cnt = '0;
                        end
                        else
                        begin
                            next_q.tx = {q.tx[6:0], 1'b0};
                            next_q.sda_oe = ~q.tx[6];
                        end
                    end
                end
                ddc_pkg::ST_MACK:
                begin
                    if (rise)
                        next_q.nack = q.sda_s;
                    if (fall)
                    begin
                        if (q.nack)
                            next_q.st = ddc_pkg::ST_IGN;
                        else
                        begin
                            next_q.st = ddc_pkg::ST_TX;
                            next_q.tx = q.tx_lo ? rb[7:0] : rb[15:8];
                            next_q.sda_oe = q.tx_lo ? ~rb[7] : ~rb[15];
                            next_q.tx_lo = ~q.tx_lo;
                        end
                    end
                end
            endcase
        end
        // Register update on completion of the second data byte
        if (commit)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (q.ptr[c])
                begin
                    next_q.inp[c] = cw & ddc_pkg::DATA_MASK;
                    next_q.ch[c].power_mode = cw[ddc_pkg::PD_HI:ddc_pkg::PD_LO];
                    next_q.wr[c] = 1'b1;
                end
            end
            if (!cw[ddc_pkg::LOAD_OUTPUTS_N_BIT])
            begin
                for (int c = 0; c < 2; c++)
                begin
                    if (next_q.wr[c])
                    begin
                        next_q.ch[c].code = next_q.inp[c][ddc_pkg::CODE_MSB:0];
                        next_q.wr[c] = 1'b0;
                    end
                end
            end
            if (!cw[ddc_pkg::CLR_BIT])
            begin
                next_q.inp = '0;
                next_q.wr = '0;
                for (int c = 0; c < 2; c++)
                    next_q.ch[c].code = '0;
            end
        end
    end

    // ========================================
    // Registers; reset gives normal mode and zero code
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            q <= '0;
            // Idle bus is high; a zero here would fake an edge
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_d <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_d <= 1'b1;
        end
        else
            q <= next_q;
    end

    // SDA is only ever pulled low; SCL has no driver here
    assign sda_out = q.sda_o;
    assign sda_oe = q.sda_oe;
    assign chan_a = q.ch[ddc_pkg::SEL_A];
    assign chan_b = q.ch[ddc_pkg::SEL_B];

    // ========================================
    // Assertions
    a_addr_ack_match: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.st == ddc_pkg::ST_ADDR && fall && q.cnt == ddc_pkg::BYTE_BITS
         && q.shift[7:1] == own_addr && !start && !stop)
        |=> (q.st == ddc_pkg::ST_ACK && q.sda_oe))
        else $error("own address not acknowledged");

    a_mismatch_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.st == ddc_pkg::ST_IGN) |-> !q.sda_oe)
        else $error("sda driven after mismatch");

    a_sda_scl_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        ($changed(q.sda_oe) && !$past(start) && !$past(stop)) |-> !q.scl_d)
        else $error("sda changed while scl high");

    a_clear_zeros: assert property (@(posedge sys_clk) disable iff (!resetn)
        (commit && !cw[ddc_pkg::CLR_BIT])
        |=> (q.inp == '0 && q.ch[0].code == '0 && q.ch[1].code == '0))
        else $error("clear left data behind");

    a_load_both: assert property (@(posedge sys_clk) disable iff (!resetn)
        (commit && cw[ddc_pkg::CLR_BIT] && !cw[ddc_pkg::LOAD_OUTPUTS_N_BIT] && q.ptr == 2'h3)
        |=> (q.ch[0].code == q.inp[0][11:0] && q.ch[1].code == q.inp[1][11:0] && q.wr == '0))
        else $error("load did not copy both channels");

    a_hold_outputs: assert property (@(posedge sys_clk) disable iff (!resetn)
        (commit && cw[ddc_pkg::CLR_BIT] && cw[ddc_pkg::LOAD_OUTPUTS_N_BIT])
        |=> ($stable(q.ch[0].code) && $stable(q.ch[1].code)))
        else $error("output changed without load");

    a_reset_zero: assert property (@(posedge sys_clk)
        $rose(resetn) |-> (q.inp == '0 && q.ch == '0 && q.ptr == '0 && !q.sda_oe))
        else $error("reset state not zero");

    a_default_rb: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.st == ddc_pkg::ST_ACK && fall && q.rw && !start && !stop
         && q.ptr != ddc_pkg::PTR_ONLY_A && q.ptr != ddc_pkg::PTR_ONLY_B)
        |=> (q.tx == ddc_pkg::READBACK_DEFAULT[15:8] && q.sda_oe))
        else $error("default readback wrong");

    a_write_route: assert property (@(posedge sys_clk) disable iff (!resetn)
        (commit && cw[ddc_pkg::CLR_BIT] && q.ptr == ddc_pkg::PTR_ONLY_A)
        |=> $stable(q.inp[1]))
        else $error("unselected channel written");

    c_write_done: cover property (@(posedge sys_clk) disable iff (!resetn) commit);
    c_load_write: cover property (@(posedge sys_clk) disable iff (!resetn)
        commit && !cw[ddc_pkg::LOAD_OUTPUTS_N_BIT]);
    c_read_repeat: cover property (@(posedge sys_clk) disable iff (!resetn)
        q.st == ddc_pkg::ST_MACK && fall && !q.nack && !q.tx_lo);
    c_mismatch: cover property (@(posedge sys_clk) disable iff (!resetn)
        q.st == ddc_pkg::ST_IGN);

endmodule : ddc_top

`default_nettype wire

// ---- dv/ddc_master.sv ----
// Behavioural two-wire bus master for the converter control block
`timescale 1ns/1ps
`default_nettype none

module ddc_master (
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low,
    output logic [8:0] got,
    output logic got_stb
);
    // ========================================
    // Idle bus: clock stands high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        got = 9'h000;
        got_stb = 1'b0;
    end

    // ========================================
    // Conditions; also serves a repeated start from a low clock
    task automatic start_cond();
        sda_low = 1'b0;
        #200 scl = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
        #200;
    endtask : start_cond

    task automatic stop_cond();
        sda_low = 1'b1;
        #200 scl = 1'b1;
        #200 sda_low = 1'b0;
        #400;
    endtask : stop_cond

    // Nine pulses; data moves mid-low so it is steady while high
    task automatic bits9(input logic [8:0] d);
        logic [8:0] q;
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = ~d[i];
            #200 scl = 1'b1;
            #200 q[i] = sda_wire;
            #200 scl = 1'b0;
            #200;
        end
        got = q;
        got_stb = ~got_stb;
    endtask : bits9
endmodule : ddc_master
`default_nettype wire

// ---- dv/ddc_top_tb.sv ----
// Self-checking bench for the converter two-wire control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end

module ddc_top_tb;
    logic sys_clk, resetn, scl, sda_low, sda_oe, sda_out, strap, got_stb;
    logic [8:0] got, er;
    ddc_pkg::ddc_chan_s chan_a, chan_b;
    logic [27:0] last_out, exp_out, eo;
    logic [27:0] eq[$];
    logic [8:0] rq[$];
    logic [15:0] seed;
    logic [15:0] inp[2];
    logic [1:0] ptr, wrf;
    int error_cnt, num_checks, cyc;
    wire logic sda_wire = ~((sda_oe & ~sda_out) | sda_low);

    ddc_top #(.ALT_BUILD(1'b0)) i_ddc_top (.sys_clk(sys_clk), .resetn(resetn), .scl(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_pin(strap), .chan_a(chan_a), .chan_b(chan_b));
    ddc_master i_ddc_master (.sda_wire(sda_wire), .scl(scl), .sda_low(sda_low), .got(got),
        .got_stb(got_stb));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ========================================
    // Expected-value model
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic commit(input logic [1:0] p, input logic [15:0] w);
        logic [27:0] o;
        o = exp_out;
        for (int c = 0; c < 2; c++)
            if (p[c])
            begin
                inp[c] = w;
                wrf[c] = 1'b1;
                o[14 * c + 12 +: 2] = w[15:14];
            end
        for (int c = 0; c < 2; c++)
            if (!w[13])
            begin
                inp[c] = 16'h0000;
                o[14 * c +: 12] = 12'h000;
            end
            else if (!w[12] && wrf[c])
                o[14 * c +: 12] = inp[c][11:0];
        if (!w[13] || !w[12])
            wrf = 2'h0;
        if (o !== exp_out)
            eq.push_back(o);
        exp_out = o;
    endtask : commit

    task automatic xb(input logic [8:0] d, input logic [8:0] e);
        rq.push_back(e);
        i_ddc_master.bits9(d);
    endtask : xb

    // Bad address uses the alternate build's upper bits
    task automatic wr(input logic bad, input logic [7:0] p, input logic [15:0] w, input int n);
        logic [6:0] a;
        a = bad ? {6'h11, strap} : {6'h06, strap};
        if (!bad)
            ptr = p[1:0];
        if (!bad && n > 1)
            commit(p[1:0], w);
        i_ddc_master.start_cond();
        xb({a, 2'h1}, {a, 1'b0, bad});
        xb({p, 1'b1}, {p, bad});
        for (int i = 0; i < n; i++)
            xb({w[15 - 8 * i -: 8], 1'b1}, {w[15 - 8 * i -: 8], bad});
        i_ddc_master.stop_cond();
    endtask : wr

    task automatic rd(input logic usep, input logic [1:0] p, input int n);
        logic [15:0] w;
        i_ddc_master.start_cond();
        if (usep)
        begin
            ptr = p;
            xb({6'h06, strap, 2'h1}, {6'h06, strap, 2'h0});
            xb({6'h00, p, 1'b1}, {6'h00, p, 1'b0});
            i_ddc_master.start_cond();
        end
        w = (ptr == 2'h1) ? inp[0] : (ptr == 2'h2) ? inp[1] : 16'h2000;
        xb({6'h06, strap, 2'h3}, {6'h06, strap, 2'h2});
        for (int i = 0; i < n; i++)
            xb({8'hff, i == n - 1}, {w[15 - 8 * (i % 2) -: 8], i == n - 1});
        i_ddc_master.stop_cond();
    endtask : rd

    // ========================================
    // Output watchers
    always @(negedge sys_clk)
        if (resetn === 1'b1 && {chan_b, chan_a} !== last_out)
        begin
            last_out = {chan_b, chan_a};
            eo = eq.size() ? eq.pop_front() : 28'hx;
            `CHK("outputs", eo, last_out)
        end

    always @(got_stb)
        if (resetn === 1'b1)
        begin
            er = rq.size() ? rq.pop_front() : 9'hx;
            `CHK("bus byte", er, got)
        end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Whole sequence needs about 6000 cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        seed = 16'h0014;
        strap = seed[2];
        exp_out = 28'h0;
        last_out = 28'h0;
        inp[0] = 16'h0000;
        inp[1] = 16'h0000;
        ptr = 2'h0;
        wrf = 2'h0;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        repeat (6) @(posedge sys_clk);
        #10 resetn = 1'b1;
        repeat (5) @(posedge sys_clk);
        // Bus moves stay off the sampling edge from here on
        #10;
        `CHK("reset outputs", 28'h0, {chan_b, chan_a})
        rd(1'b0, 2'h0, 2);
        for (int m = 0; m < 4; m++)
        begin
            seed = lfsr(seed);
            strap = seed[5];
            wr(1'b0, 8'hc1, {2'(m), 2'h3, seed[11:0]}, 2);
            rd(1'b1, 2'h1, 4);
        end
        seed = lfsr(seed);
        wr(1'b0, 8'h02, {4'h2, seed[11:0]}, 2);
        seed = lfsr(seed);
        wr(1'b0, 8'h02, {4'h2, seed[11:0]}, 2);
        wr(1'b1, 8'h03, 16'hffff, 2);
        seed = lfsr(seed);
        wr(1'b0, 8'h01, {4'h2, seed[11:0]}, 1);
        seed = lfsr(seed);
        wr(1'b0, 8'h03, {4'h6, seed[11:0]}, 2);
        rd(1'b0, 2'h0, 2);
        wr(1'b0, 8'h03, 16'h0000, 2);
        rd(1'b1, 2'h1, 2);
        repeat (20) @(posedge sys_clk);
        `CHK("pending notes", 0, eq.size() + rq.size())
        report_and_stop();
    end
endmodule : ddc_top_tb
`default_nettype wire
